// ### ucf_pkg.sv
// Purpose: Shared constants and types for the control endpoint and endpoint FIFO allocator
// Assumes: 32-bit Avalon-MM register access, byte addresses
// Notes: Offsets are word aligned
package ucf_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] UCF_OFS_CTRL = 6'h00;
  localparam logic [5:0] UCF_OFS_CEP = 6'h04;
  localparam logic [5:0] UCF_OFS_CNT = 6'h08;
  localparam logic [5:0] UCF_OFS_ADDR = 6'h0c;
  localparam logic [5:0] UCF_OFS_INDEX = 6'h10;
  localparam logic [5:0] UCF_OFS_EPCFG = 6'h14;
  localparam logic [5:0] UCF_OFS_MAXI = 6'h18;
  localparam logic [5:0] UCF_OFS_MAXO = 6'h1c;
  localparam logic [5:0] UCF_OFS_ALLOC = 6'h20;

  // ----------------------------------------
  // Control endpoint status bit positions
  // ----------------------------------------
  localparam int UCF_B_RXRDY = 0;
  localparam int UCF_B_TXRDY = 1;
  localparam int UCF_B_SENT_STALL = 2;
  localparam int UCF_B_DATA_END = 3;
  localparam int UCF_B_PREM_END = 4;
  localparam int UCF_B_SEND_STALL = 5;
  localparam int UCF_B_RX_RELEASE = 6;
  localparam int UCF_B_PREM_CLEAR = 7;

  // Endpoint config bit positions
  localparam int UCF_B_IN_ISO = 0;
  localparam int UCF_B_OUT_ISO = 1;
  localparam int UCF_B_IN_DBL = 2;
  localparam int UCF_B_OUT_DBL = 3;

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam logic [5:0] UCF_CEP_MAX_PKT = 6'h20;
  localparam logic [3:0] UCF_SETUP_LEN = 4'h8;
  localparam int UCF_NUM_EP = 5;
  localparam logic [9:0] UCF_FIFO_BASE = 10'h020;
  localparam logic [6:0] UCF_ADDR_RST = 7'h00;
  localparam logic [31:0] UCF_UNMAPPED_RD = 32'h0000_0000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    UCF_ST_IDLE = 2'b00,
    UCF_ST_TX = 2'b01,
    UCF_ST_RX = 2'b10
  } ucf_state_t;

  typedef enum logic [1:0] {
    UCF_PID_OUT = 2'b00,
    UCF_PID_IN = 2'b01,
    UCF_PID_SETUP = 2'b10
  } ucf_tok_t;

  typedef enum logic [1:0] {
    UCF_HS_NONE = 2'b00,
    UCF_HS_ACK = 2'b01,
    UCF_HS_NAK = 2'b10,
    UCF_HS_STALL = 2'b11
  } ucf_hs_t;

  // Packet event from the serial engine for the control endpoint
  typedef struct packed {
    logic valid;
    ucf_tok_t tok;
    logic data1;
    logic [9:0] len;
  } ucf_pkt_t;

  // Handshake answer back to the serial engine
  typedef struct packed {
    logic valid;
    ucf_hs_t hs;
  } ucf_ans_t;

endpackage : ucf_pkg

// ### ucf_ctrl.sv
// Purpose: Control endpoint transfer state machine and endpoint 1-5 FIFO allocation
// Assumes: Serial engine delivers one decoded control-endpoint event per pulse
// Notes: One clock; Avalon-MM slave answers each access after one wait cycle
//
// Functional notes
// - Protocol error stalls, sets stall-sent, interrupts
// - Extra token after data-end is error
// - Oversized OUT data packet is error
// - Nonzero status DATA1 length is error
// - Send-stall bit stalls following requests
// - Unexpected data-stage token sets premature end
// - Setup accepted only at eight bytes
// - Setup decode; release moves to TX/RX
// - Received packet sets ready and interrupts
// - TX takes IN only; NAK without data
// - Sent packet clears ready; status ends idle
// - RX takes OUT only; data-end starts status
// - Bad OUT status stage stalls and interrupts
// - Byte count valid while ready set
// - Per-direction isochronous or bulk select
// - FIFO regions 32 to 512 bytes
// - Single buffering: IN top, OUT bottom
// - Double buffering: second buffers at midpoint
// - Control endpoint 32 bytes, single buffer
// - Only control endpoint until address set
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ucf_ctrl
  import ucf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ctrl_enable,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire ucf_pkt_t pkt_in,
  input wire logic setup_has_data,
  input wire logic setup_dir_in,
  input wire logic [6:0] tok_addr,
  input wire logic [3:0] tok_ep,
  output ucf_ans_t ans_out,
  output logic cep_irq,
  output logic addr_match,
  output logic ep_usable
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic ack_r;
  logic wr_go;
  logic cep_wr;
  logic [31:0] rdata_nxt;

  ucf_state_t state_r;
  logic rxrdy_r, txrdy_r, sent_stall_r, data_end_r, prem_end_r, send_stall_r;
  logic status_stage_r;
  logic dir_in_r, has_data_r;
  logic [9:0] cnt_r;
  logic [6:0] func_addr_r;
  logic [2:0] index_r;
  logic [3:0] epcfg_r [UCF_NUM_EP];
  logic [9:0] maxi_r [UCF_NUM_EP];
  logic [9:0] maxo_r [UCF_NUM_EP];
  logic [9:0] in_top [UCF_NUM_EP];
  logic [9:0] out_bot [UCF_NUM_EP];
  logic [9:0] mid [UCF_NUM_EP];
  logic [UCF_NUM_EP-1:0] fit_ok;
  logic sel_ok;
  logic [2:0] sel;

  // One wait cycle, then the access completes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r & avs_byteenable[0];
  assign cep_wr = wr_go & (avs_address == UCF_OFS_CEP);
  assign sel = index_r - 3'd1;
  assign sel_ok = (index_r != 3'd0) && (index_r <= 3'(UCF_NUM_EP));

  // ----------------------------------------
  // Control endpoint state machine
  // ----------------------------------------
  logic err_stall;
  logic prem_evt;
  logic rx_evt;
  logic tx_done;
  logic status_done;
  ucf_hs_t hs_nxt;
  ucf_state_t state_nxt;

  always_comb begin
    err_stall = 1'b0;
    prem_evt = 1'b0;
    rx_evt = 1'b0;
    tx_done = 1'b0;
    status_done = 1'b0;
    hs_nxt = UCF_HS_NONE;
    state_nxt = state_r;
    if (pkt_in.valid && ctrl_enable) begin
      if (pkt_in.tok == UCF_PID_SETUP) begin
        // Setup always restarts; a setup in a data stage is premature
        if (state_r != UCF_ST_IDLE) begin
          prem_evt = 1'b1;
        end
        state_nxt = UCF_ST_IDLE;
        if (pkt_in.len == 10'(UCF_SETUP_LEN)) begin
          rx_evt = 1'b1;
          hs_nxt = UCF_HS_ACK;
        end
      end else if (send_stall_r) begin
        hs_nxt = UCF_HS_STALL;
        err_stall = 1'b1;
        state_nxt = UCF_ST_IDLE;
      end else if (status_stage_r && !(state_r == UCF_ST_TX && txrdy_r)) begin
        // Status stage once the last loaded IN packet has gone
        if (dir_in_r && pkt_in.tok == UCF_PID_IN) begin
          err_stall = 1'b1;
        end else if (!dir_in_r && pkt_in.tok == UCF_PID_OUT) begin
          err_stall = 1'b1;
        end else if (pkt_in.tok == UCF_PID_OUT && pkt_in.len != 10'h000) begin
          err_stall = 1'b1;
        end else begin
          status_done = 1'b1;
          hs_nxt = (pkt_in.tok == UCF_PID_IN) ? UCF_HS_NONE : UCF_HS_ACK;
        end
        if (err_stall) begin
          hs_nxt = UCF_HS_STALL;
        end
        state_nxt = UCF_ST_IDLE;
      end else begin
        unique case (state_r)
          UCF_ST_IDLE: begin
            hs_nxt = UCF_HS_NAK;
          end
          UCF_ST_TX: begin
            if (pkt_in.tok != UCF_PID_IN) begin
              prem_evt = 1'b1;
              state_nxt = UCF_ST_IDLE;
            end else if (!txrdy_r) begin
              hs_nxt = UCF_HS_NAK;
            end else begin
              tx_done = 1'b1;
            end
          end
          UCF_ST_RX: begin
            if (pkt_in.tok != UCF_PID_OUT) begin
              prem_evt = 1'b1;
              state_nxt = UCF_ST_IDLE;
            end else if (pkt_in.len > 10'(UCF_CEP_MAX_PKT)) begin
              err_stall = 1'b1;
              hs_nxt = UCF_HS_STALL;
              state_nxt = UCF_ST_IDLE;
            end else if (rxrdy_r) begin
              hs_nxt = UCF_HS_NAK;
            end else begin
              rx_evt = 1'b1;
              hs_nxt = UCF_HS_ACK;
            end
          end
          default: begin
            state_nxt = UCF_ST_IDLE;
          end
        endcase
      end
    end
    // Release of setup with data stage moves to TX or RX
    if (cep_wr && avs_writedata[UCF_B_RX_RELEASE] && !avs_writedata[UCF_B_DATA_END]
        && state_r == UCF_ST_IDLE && has_data_r && !(pkt_in.valid && ctrl_enable)) begin
      state_nxt = dir_in_r ? UCF_ST_TX : UCF_ST_RX;
    end
  end

  // State register; enable clear holds everything idle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= UCF_ST_IDLE;
    end else if (!ctrl_enable) begin
      state_r <= UCF_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Setup decode latch
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      has_data_r <= 1'b0;
      dir_in_r <= 1'b0;
    end else if (pkt_in.valid && ctrl_enable && pkt_in.tok == UCF_PID_SETUP && rx_evt) begin
      has_data_r <= setup_has_data;
      dir_in_r <= setup_dir_in;
    end
  end

  // Packet ready, data-end and byte count; hardware set wins over software clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxrdy_r <= 1'b0;
      txrdy_r <= 1'b0;
      data_end_r <= 1'b0;
      status_stage_r <= 1'b0;
      cnt_r <= 10'h000;
    end else if (!ctrl_enable) begin
      rxrdy_r <= 1'b0;
      txrdy_r <= 1'b0;
      data_end_r <= 1'b0;
      status_stage_r <= 1'b0;
      cnt_r <= 10'h000;
    end else begin
      if (cep_wr) begin
        if (avs_writedata[UCF_B_RX_RELEASE]) rxrdy_r <= 1'b0;
        if (avs_writedata[UCF_B_TXRDY]) txrdy_r <= 1'b1;
        if (avs_writedata[UCF_B_DATA_END]) begin
          data_end_r <= 1'b1;
          status_stage_r <= 1'b1;
        end
      end
      if (rx_evt) begin
        rxrdy_r <= 1'b1;
        cnt_r <= pkt_in.len;
      end
      if (tx_done) txrdy_r <= 1'b0;
      if (status_done || err_stall || prem_evt || (rx_evt && pkt_in.tok == UCF_PID_SETUP)) begin
        data_end_r <= 1'b0;
        status_stage_r <= 1'b0;
      end
    end
  end

  // Stall and premature-end flags; the hardware event wins over a clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sent_stall_r <= 1'b0;
      prem_end_r <= 1'b0;
      send_stall_r <= 1'b0;
    end else if (!ctrl_enable) begin
      sent_stall_r <= 1'b0;
      prem_end_r <= 1'b0;
      send_stall_r <= 1'b0;
    end else begin
      if (cep_wr) begin
        if (!avs_writedata[UCF_B_SENT_STALL]) sent_stall_r <= 1'b0;
        if (avs_writedata[UCF_B_PREM_CLEAR]) prem_end_r <= 1'b0;
        send_stall_r <= avs_writedata[UCF_B_SEND_STALL];
      end
      if (err_stall) sent_stall_r <= 1'b1;
      if (prem_evt) prem_end_r <= 1'b1;
    end
  end

  // Handshake answer, one cycle after the token
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ans_out <= '0;
    end else begin
      ans_out.valid <= (hs_nxt != UCF_HS_NONE);
      ans_out.hs <= hs_nxt;
    end
  end

  // Event interrupt pulse
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cep_irq <= 1'b0;
    end else begin
      cep_irq <= rx_evt | tx_done | status_done | err_stall | prem_evt;
    end
  end

  // ----------------------------------------
  // Address and endpoint configuration
  // ----------------------------------------
  // Function address; enable clear returns to the default address
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      func_addr_r <= UCF_ADDR_RST;
    end else if (!ctrl_enable) begin
      func_addr_r <= UCF_ADDR_RST;
    end else if (wr_go && avs_address == UCF_OFS_ADDR) begin
      func_addr_r <= avs_writedata[6:0];
    end
  end

  // Endpoint select index for the indexed registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      index_r <= 3'd0;
    end else if (!ctrl_enable) begin
      index_r <= 3'd0;
    end else if (wr_go && avs_address == UCF_OFS_INDEX) begin
      index_r <= avs_writedata[2:0];
    end
  end

  // Only the control endpoint answers until an address is assigned
  assign addr_match = (tok_addr == func_addr_r);
  assign ep_usable = addr_match && ((tok_ep == 4'd0) ||
                     (func_addr_r != 7'd0 && tok_ep <= 4'(UCF_NUM_EP)));

  // Per-endpoint config and FIFO placement
  genvar g;
  generate
    for (g = 0; g < UCF_NUM_EP; g++) begin : g_ep
      localparam logic [9:0] SIZE = 10'(UCF_FIFO_BASE << g);
      localparam logic [9:0] BASE = 10'(UCF_FIFO_BASE * ((1 << g) - 1));
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          epcfg_r[g] <= 4'h0;
          maxi_r[g] <= 10'h000;
          maxo_r[g] <= 10'h000;
        end else if (wr_go && sel_ok && sel == 3'(g)) begin
          if (avs_address == UCF_OFS_EPCFG) epcfg_r[g] <= avs_writedata[3:0];
          if (avs_address == UCF_OFS_MAXI) maxi_r[g] <= avs_writedata[9:0];
          if (avs_address == UCF_OFS_MAXO) maxo_r[g] <= avs_writedata[9:0];
        end
      end
      assign mid[g] = BASE + (SIZE >> 1);
      assign in_top[g] = BASE + SIZE - 10'd1;
      assign out_bot[g] = BASE;
      // Sum limit: whole region single, half region when either doubles
      assign fit_ok[g] = (epcfg_r[g][UCF_B_IN_DBL] | epcfg_r[g][UCF_B_OUT_DBL]) ?
                         (11'(maxi_r[g]) + 11'(maxo_r[g]) <= 11'(SIZE >> 1)) :
                         (11'(maxi_r[g]) + 11'(maxo_r[g]) <= 11'(SIZE));
    end
  endgenerate

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rdata_nxt = UCF_UNMAPPED_RD;
    unique case (avs_address)
      UCF_OFS_CTRL: rdata_nxt = {29'd0, 2'(state_r), ctrl_enable};
      UCF_OFS_CEP: rdata_nxt = {26'd0, send_stall_r, prem_end_r, data_end_r,
                                sent_stall_r, txrdy_r, rxrdy_r};
      UCF_OFS_CNT: rdata_nxt = {22'd0, cnt_r};
      UCF_OFS_ADDR: rdata_nxt = {25'd0, func_addr_r};
      UCF_OFS_INDEX: rdata_nxt = {29'd0, index_r};
      UCF_OFS_EPCFG: if (sel_ok) rdata_nxt = {28'd0, epcfg_r[sel]};
      UCF_OFS_MAXI: if (sel_ok) rdata_nxt = {22'd0, maxi_r[sel]};
      UCF_OFS_MAXO: if (sel_ok) rdata_nxt = {22'd0, maxo_r[sel]};
      UCF_OFS_ALLOC: if (sel_ok) rdata_nxt = {1'b0, fit_ok[sel], in_top[sel], mid[sel], out_bot[sel]};
      default: rdata_nxt = UCF_UNMAPPED_RD;
    endcase
  end

  // Registered read data, valid with waitrequest low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rdata_nxt;
    end
  end

endmodule : ucf_ctrl

`default_nettype wire

// ### ucf_ctrl_asserts.sv
// Purpose: Concurrent checks on the control endpoint ports
// Assumes: One clock domain, reset_n active low
// Notes: Bound to every ucf_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module ucf_ctrl_asserts
  import ucf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ctrl_enable,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire ucf_pkt_t pkt_in,
  input wire logic [3:0] tok_ep,
  input wire ucf_ans_t ans_out,
  input wire logic cep_irq,
  input wire logic addr_match,
  input wire logic ep_usable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Event steps
  // ----------------------------------------
  sequence setup_ok;
    pkt_in.valid && ctrl_enable && pkt_in.tok == UCF_PID_SETUP && pkt_in.len == 10'h008;
  endsequence
  sequence ack_pulse;
    ans_out.valid && ans_out.hs == UCF_HS_ACK && cep_irq ##1 !ans_out.valid;
  endsequence
  bus_one_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait not one cycle");
  setup_ack_a: assert property (setup_ok |=> ack_pulse)
    else $error("good setup not acked");
  setup_reject_a: assert property (pkt_in.valid && ctrl_enable && pkt_in.tok == UCF_PID_SETUP &&
    pkt_in.len != 10'h008 |=> !ans_out.valid) else $error("bad setup answered");
  ans_cause_a: assert property (!(pkt_in.valid && ctrl_enable) |=> !ans_out.valid)
    else $error("answer without token");
  disabled_quiet_a: assert property (!ctrl_enable |=> !ans_out.valid && !cep_irq)
    else $error("activity while disabled");
  stall_irq_a: assert property (ans_out.valid && ans_out.hs == UCF_HS_STALL |-> cep_irq)
    else $error("stall without interrupt");
  irq_pulse_a: assert property (cep_irq |=> !cep_irq)
    else $error("interrupt longer than a cycle");
  ep0_usable_a: assert property (addr_match && tok_ep == 4'h0 |-> ep_usable)
    else $error("control endpoint unusable");
  ep_range_a: assert property (tok_ep > 4'h5 |-> !ep_usable)
    else $error("endpoint above five usable");
endmodule : ucf_ctrl_asserts
bind ucf_ctrl ucf_ctrl_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .ctrl_enable(ctrl_enable),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .pkt_in(pkt_in),
  .tok_ep(tok_ep), .ans_out(ans_out), .cep_irq(cep_irq), .addr_match(addr_match), .ep_usable(ep_usable));
`default_nettype wire

// ### ucf_host_model.sv
// Purpose: Host side token source for the control endpoint
// Assumes: Answer and interrupt arrive one cycle after the event
// Notes: Released fields carry inverted values, never the last one
`timescale 1ns/1ps
`default_nettype none
module ucf_host_model
  import ucf_pkg::*;
(
  input wire logic clk_sys,
  input wire ucf_ans_t ans_out,
  input wire logic cep_irq,
  output ucf_pkt_t pkt_in,
  output logic setup_has_data,
  output logic setup_dir_in,
  output logic [6:0] tok_addr,
  output logic [3:0] tok_ep
);
  // Quiet bus at time zero
  initial begin
    pkt_in = '0;
    setup_has_data = 1'h0;
    setup_dir_in = 1'h0;
    tok_addr = 7'h00;
    tok_ep = 4'h0;
  end
  // Point tokens at an address and endpoint
  task automatic aim(input logic [6:0] a, input logic [3:0] e);
    @(posedge clk_sys);
    tok_addr <= a;
    tok_ep <= e;
  endtask : aim
  // One event pulse, then collect {irq, answer}
  task automatic send(input ucf_tok_t t, input logic [9:0] n, input logic d1, input logic hd,
    input logic din, output logic [3:0] res);
    @(posedge clk_sys);
    pkt_in <= '{1'h1, t, d1, n};
    setup_has_data <= hd;
    setup_dir_in <= din;
    @(posedge clk_sys);
    pkt_in <= '{1'h0, ucf_tok_t'(~t), ~d1, ~n}; // Gap of one cycle between events
    setup_has_data <= ~hd;
    setup_dir_in <= ~din;
    #1;
    res = {cep_irq, ans_out};
  endtask : send
endmodule : ucf_host_model
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for the control endpoint and FIFO allocator
// Assumes: Register access over Avalon-MM, host events via the host model
// Notes: Firmware role is played by the register tasks
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ucf_pkg::*;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic ctrl_enable = 1'h0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  ucf_pkt_t pkt_in;
  logic setup_has_data, setup_dir_in, addr_match, ep_usable, cep_irq;
  logic [6:0] tok_addr;
  logic [3:0] tok_ep;
  ucf_ans_t ans_out;
  int num_errors = 0;
  int num_checks = 0;
  int sz;
  ucf_ctrl uut (.clk_sys(clk_sys), .reset_n(reset_n), .ctrl_enable(ctrl_enable), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pkt_in(pkt_in),
    .setup_has_data(setup_has_data), .setup_dir_in(setup_dir_in), .tok_addr(tok_addr), .tok_ep(tok_ep),
    .ans_out(ans_out), .cep_irq(cep_irq), .addr_match(addr_match), .ep_usable(ep_usable));
  ucf_host_model host (.clk_sys(clk_sys), .ans_out(ans_out), .cep_irq(cep_irq), .pkt_in(pkt_in),
    .setup_has_data(setup_has_data), .setup_dir_in(setup_dir_in), .tok_addr(tok_addr), .tok_ep(tok_ep));
  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // One Avalon cycle: hold until waitrequest low, take data at that edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    check(q & m, e);
  endtask : rd
  task automatic tk(input ucf_tok_t t, input logic [9:0] n, input logic d1, input logic din,
    input logic [3:0] e, input logic [3:0] m);
    logic [3:0] r;
    host.send(t, n, d1, 1'h1, din, r);
    check({28'h0, r & m}, {28'h0, e});
  endtask : tk
  task automatic restart();
    @(posedge clk_sys);
    ctrl_enable <= 1'h0;
    @(posedge clk_sys);
    ctrl_enable <= 1'h1;
  endtask : restart
  // Accepted setup then release into the data stage
  task automatic open(input logic din);
    restart();
    tk(UCF_PID_SETUP, 10'h008, 1'h0, din, 4'hd, 4'hf);
    wr(UCF_OFS_CEP, 32'h40);
  endtask : open
  // Watchdog
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'h1;
    rd(UCF_OFS_CTRL, 32'h0, 32'hffffffff);
    restart();
    rd(UCF_OFS_CTRL, 32'h1, 32'hffffffff);
    rd(UCF_OFS_CEP, 32'h0, 32'hff);
    rd(6'h3c, UCF_UNMAPPED_RD, 32'hffffffff);
    $display("reset test done");
    tk(UCF_PID_SETUP, 10'h007, 1'h0, 1'h1, 4'h0, 4'hf);
    rd(UCF_OFS_CEP, 32'h0, 32'h1);
    open(1'h1);
    rd(UCF_OFS_CTRL, 32'h3, 32'h7);
    tk(UCF_PID_IN, 10'h000, 1'h0, 1'h0, 4'h6, 4'hf);
    wr(UCF_OFS_CEP, 32'h02);
    tk(UCF_PID_IN, 10'h000, 1'h0, 1'h0, 4'h8, 4'hc);
    rd(UCF_OFS_CEP, 32'h0, 32'h2);
    wr(UCF_OFS_CEP, 32'h08);
    tk(UCF_PID_IN, 10'h000, 1'h0, 1'h0, 4'hf, 4'hf);
    rd(UCF_OFS_CEP, 32'h4, 32'h4);
    wr(UCF_OFS_CEP, 32'h00);
    rd(UCF_OFS_CEP, 32'h0, 32'h4);
    open(1'h1);
    wr(UCF_OFS_CEP, 32'h02);
    tk(UCF_PID_IN, 10'h000, 1'h0, 1'h0, 4'h8, 4'hc);
    wr(UCF_OFS_CEP, 32'h08);
    tk(UCF_PID_OUT, 10'h000, 1'h1, 1'h0, 4'h8, 4'h8);
    rd(UCF_OFS_CTRL, 32'h1, 32'h7);
    open(1'h1);
    wr(UCF_OFS_CEP, 32'h0a);
    tk(UCF_PID_IN, 10'h000, 1'h0, 1'h0, 4'h8, 4'hf);
    tk(UCF_PID_OUT, 10'h003, 1'h1, 1'h0, 4'hf, 4'hf);
    rd(UCF_OFS_CEP, 32'h4, 32'h4);
    $display("in transfer test done");
    open(1'h0);
    rd(UCF_OFS_CTRL, 32'h5, 32'h7);
    tk(UCF_PID_OUT, 10'h020, 1'h1, 1'h0, 4'hd, 4'hf);
    rd(UCF_OFS_CNT, 32'h20, 32'h3ff);
    wr(UCF_OFS_CEP, 32'h40);
    tk(UCF_PID_OUT, 10'h021, 1'h0, 1'h0, 4'hf, 4'hf);
    open(1'h0);
    tk(UCF_PID_OUT, 10'h005, 1'h1, 1'h0, 4'hd, 4'hf);
    rd(UCF_OFS_CNT, 32'h5, 32'h3ff);
    wr(UCF_OFS_CEP, 32'h48);
    tk(UCF_PID_OUT, 10'h003, 1'h1, 1'h0, 4'hf, 4'hf);
    open(1'h0);
    tk(UCF_PID_OUT, 10'h000, 1'h1, 1'h0, 4'hd, 4'hf);
    wr(UCF_OFS_CEP, 32'h48);
    tk(UCF_PID_IN, 10'h000, 1'h0, 1'h0, 4'h8, 4'hf);
    rd(UCF_OFS_CTRL, 32'h1, 32'h7);
    $display("out transfer test done");
    open(1'h1);
    tk(UCF_PID_OUT, 10'h000, 1'h0, 1'h0, 4'h8, 4'h8);
    rd(UCF_OFS_CEP, 32'h10, 32'h10);
    rd(UCF_OFS_CTRL, 32'h1, 32'h7);
    wr(UCF_OFS_CEP, 32'h80);
    rd(UCF_OFS_CEP, 32'h0, 32'h10);
    open(1'h1);
    wr(UCF_OFS_CEP, 32'h20);
    tk(UCF_PID_IN, 10'h000, 1'h0, 1'h0, 4'hf, 4'hf);
    rd(UCF_OFS_CEP, 32'h24, 32'h24);
    restart();
    rd(UCF_OFS_CEP, 32'h0, 32'hff);
    $display("stall test done");
    for (int e = 1; e <= UCF_NUM_EP; e++) begin
      sz = 32 << (e - 1);
      wr(UCF_OFS_INDEX, e);
      wr(UCF_OFS_EPCFG, 32'h3);
      rd(UCF_OFS_EPCFG, 32'h3, 32'hf);
      wr(UCF_OFS_MAXI, sz / 2);
      wr(UCF_OFS_MAXO, sz / 2);
      rd(UCF_OFS_ALLOC, 32'h40000000 | ((2 * sz - 33) << 20) | ((sz + sz / 2 - 32) << 10) | (sz - 32),
        32'h7fffffff);
      wr(UCF_OFS_MAXO, sz / 2 + 1);
      rd(UCF_OFS_ALLOC, 32'h0, 32'h40000000);
      wr(UCF_OFS_EPCFG, 32'h4);
      wr(UCF_OFS_MAXI, sz / 4);
      wr(UCF_OFS_MAXO, sz / 4);
      rd(UCF_OFS_ALLOC, 32'h40000000, 32'h40000000);
      wr(UCF_OFS_MAXO, sz / 4 + 1);
      rd(UCF_OFS_ALLOC, 32'h0, 32'h40000000);
      wr(UCF_OFS_EPCFG, 32'h0);
      rd(UCF_OFS_EPCFG, 32'h0, 32'hf);
      wr(UCF_OFS_MAXI, 32'h0);
      wr(UCF_OFS_MAXO, 32'h0);
      rd(UCF_OFS_ALLOC, 32'h40000000, 32'h40000000);
    end
    wr(UCF_OFS_INDEX, 32'h0);
    rd(UCF_OFS_MAXI, 32'h0, 32'hffffffff);
    $display("fifo test done");
    host.aim(7'h00, 4'h2);
    @(posedge clk_sys);
    check({30'h0, addr_match, ep_usable}, 32'h2);
    wr(UCF_OFS_ADDR, 32'h05);
    rd(UCF_OFS_ADDR, 32'h5, 32'h7f);
    check({30'h0, addr_match, ep_usable}, 32'h0);
    host.aim(7'h05, 4'h2);
    @(posedge clk_sys);
    check({30'h0, addr_match, ep_usable}, 32'h3);
    $display("address test done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
